// *** sim/mgmt_host_model.sv ***
// Station management host model that runs framed register accesses.
`timescale 1ns/100ps
`default_nettype none
`include "phy_aux_control_map.vh"

module mgmt_host_model (
    input  wire logic core_clk_i,
    input  wire logic mdio_i,
    output var  logic mdc_o,
    output var  logic mdio_o,
    output var  logic mdio_oe_o
);
    logic [15:0] rd_word;
    logic        ta_low;

    initial begin
        mdc_o = 1'b0;
        mdio_o = 1'b1;
        mdio_oe_o = 1'b0;
    end

    // MDC stands still between frames; data changes only while MDC is low.
    task automatic frame(input logic [1:0] op, input logic [4:0] pa,
                         input logic [4:0] ra, input logic [15:0] wd);
        logic [63:0] bits;
        bits = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
        for (int i = 63; i >= 0; i--) begin
            @(negedge core_clk_i);
            mdc_o = 1'b0;
            mdio_oe_o = !(op == `MDIO_OP_READ && i < 18);
            mdio_o = bits[i];
            repeat (4) @(negedge core_clk_i);
            if (i == 16) ta_low = !mdio_i;
            if (i < 16) rd_word[i] = mdio_i;
            mdc_o = 1'b1;
            repeat (3) @(negedge core_clk_i);
        end
        @(negedge core_clk_i);
        mdc_o = 1'b0;
        mdio_oe_o = 1'b0;
    endtask
endmodule

`default_nettype wire

// *** sim/phy_aux_control_asserts.sv ***
// Concurrent checks on the ports of the auxiliary control register bank.
`timescale 1ns/100ps
`default_nettype none

module phy_aux_control_checker (
    input wire logic       core_clk_i,
    input wire logic       rst_i,
    input wire logic       link_100_i,
    input wire logic       mac_sync_capable_i,
    input wire logic       clk_out_disable_strap_i,
    input wire logic       tx_clk_from_recovered_o,
    input wire logic       clk_out_from_recovered_o,
    input wire logic       clk_out_enable_o,
    input wire logic       alt_pinout_o,
    input wire logic       soft_reset_o,
    input wire logic [3:0] test_pattern_onehot_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence soft_pulse;
        soft_reset_o [*8] ##1 !soft_reset_o;
    endsequence
    sequence strap_high_run;
        $fell(rst_i) ##0 clk_out_disable_strap_i [*8];
    endsequence
    sequence strap_low_run;
        $fell(rst_i) ##0 !clk_out_disable_strap_i [*8];
    endsequence

    a_soft_reset_length: assert property ($rose(soft_reset_o) |-> soft_pulse)
        else $error("Soft reset pulse length wrong.");
    a_tx_needs_link: assert property (!link_100_i [*4] |=> !tx_clk_from_recovered_o)
        else $error("Transmit clock recovered at 10 Mb.");
    a_tx_needs_mac: assert property (!mac_sync_capable_i [*4] |=> !tx_clk_from_recovered_o)
        else $error("Transmit clock recovered without capable interface.");
    a_out_needs_link: assert property (!link_100_i [*4] |=> !clk_out_from_recovered_o)
        else $error("Clock output recovered at 10 Mb.");
    a_pattern_onehot: assert property ($onehot0(test_pattern_onehot_o))
        else $error("Pattern select not one-hot.");
    a_alt_enables_out: assert property (alt_pinout_o |-> clk_out_enable_o)
        else $error("Alternate pinout without clock output.");
    a_strap_disables: assert property (strap_high_run |-> !clk_out_enable_o)
        else $error("Clock output on despite strap.");
    a_strap_enables: assert property (strap_low_run |-> clk_out_enable_o)
        else $error("Clock output off without strap.");
endmodule

`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the auxiliary control register bank.
`timescale 1ns/100ps
`default_nettype none
`include "phy_aux_control_map.vh"

module testbench;
    localparam logic [4:0] LOC = 5'h05;
    localparam logic [4:0] CDT = `ADDR_COMMON_DRIVER_TEST_CONTROL;
    localparam logic [4:0] GC2 = `ADDR_GENERAL_CONTROL_TWO;
    logic        core_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        link_100_i = 1'b0;
    logic        mac_sync_capable_i = 1'b0;
    logic        strap = 1'b1;
    logic        mdc_i;
    logic        host_d;
    logic        host_oe;
    logic        mdio_o;
    logic        mdio_oe_o;
    logic        tx;
    logic        rec;
    logic        en;
    logic        alt;
    logic        sr;
    logic [3:0]  pat;
    logic [15:0] sr_run = 16'h0000;
    logic [15:0] sr_last = 16'h0000;
    int          cycles = 0;
    int          err_count = 0;
    int          n_checks = 0;
    wire  logic  mdio_pin = mdio_oe_o ? mdio_o : (host_oe ? host_d : 1'b1);

    mgmt_host_model i_host (.core_clk_i(core_clk_i), .mdio_i(mdio_pin), .mdc_o(mdc_i),
                            .mdio_o(host_d), .mdio_oe_o(host_oe));

    phy_aux_control_regs i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .mdc_i(mdc_i),
        .mdio_i(mdio_pin), .phy_addr_i(LOC), .link_100_i(link_100_i),
        .mac_sync_capable_i(mac_sync_capable_i), .clk_out_disable_strap_i(strap),
        .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .tx_clk_from_recovered_o(tx),
        .clk_out_from_recovered_o(rec), .clk_out_enable_o(en), .alt_pinout_o(alt),
        .soft_reset_o(sr), .test_pattern_onehot_o(pat));

    always #25 core_clk_i = !core_clk_i;

    // Measures the length of each soft reset pulse and cuts a hang short.
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (sr) sr_run <= sr_run + 16'h0001;
        else if (sr_run != 16'h0000) begin
            sr_last <= sr_run;
            sr_run <= 16'h0000;
        end
        if (cycles == 60000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
        i_host.frame(`MDIO_OP_WRITE, pa, ra, d);
        repeat (4) @(negedge core_clk_i);
    endtask

    task automatic rd(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] exp);
        i_host.frame(`MDIO_OP_READ, pa, ra, 16'h0000);
        chk({15'h0000, i_host.ta_low}, {15'h0000, pa == LOC});
        chk(i_host.rd_word, exp);
    endtask

    task automatic do_reset(input logic s);
        strap = s;
        rst_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        rst_i = 1'b0;
        repeat (10) @(negedge core_clk_i);
    endtask

    initial begin
        do_reset(1'b1);
        chk({15'h0000, en}, 16'h0000);
        rd(LOC, GC2, 16'h0002);
        rd(LOC, CDT, 16'h0000);
        for (int s = 0; s < 4; s++) begin
            wr(LOC, CDT, 16'h0010 | s[15:0]);
            chk({12'h000, pat}, 16'h0001 << s);
            rd(LOC, CDT, 16'h0010 | s[15:0]);
        end
        wr(LOC, CDT, 16'hffe3);
        chk({12'h000, pat}, 16'h0000);
        wr(LOC, GC2, 16'hfdfe);
        rd(LOC, GC2, 16'h3c02);
        chk({14'h0000, alt, en}, 16'h0003);
        for (int c = 0; c < 4; c++) begin
            link_100_i = c[1];
            mac_sync_capable_i = c[0];
            repeat (6) @(negedge core_clk_i);
            chk({15'h0000, tx}, {15'h0000, c == 3});
            chk({15'h0000, rec}, {15'h0000, c[1]});
        end
        wr(LOC, GC2, 16'h0000);
        chk({12'h000, tx, rec, alt, en}, 16'h0001);
        wr(5'h1f, GC2, 16'h2000);
        rd(LOC, GC2, 16'h0000);
        wr(LOC, GC2, 16'h0800);
        wr(5'h1f, GC2, 16'h2800);
        wr(5'h06, GC2, 16'h0000);
        rd(LOC, GC2, 16'h2800);
        rd(5'h1f, GC2, 16'hffff);
        chk({15'h0000, tx}, 16'h0001);
        wr(LOC, GC2, 16'h2a00);
        repeat (12) @(negedge core_clk_i);
        chk(sr_last, {8'h00, `SOFT_RESET_CYCLES});
        rd(LOC, GC2, 16'h2800);
        chk({15'h0000, tx}, 16'h0001);
        rd(LOC, 5'h10, 16'h0000);
        do_reset(1'b0);
        chk({15'h0000, en}, 16'h0001);
        rd(LOC, GC2, 16'h0000);
        stop_test();
    end
endmodule

bind phy_aux_control_regs phy_aux_control_checker i_chk (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .link_100_i(link_100_i), .mac_sync_capable_i(mac_sync_capable_i),
    .clk_out_disable_strap_i(clk_out_disable_strap_i),
    .tx_clk_from_recovered_o(tx_clk_from_recovered_o),
    .clk_out_from_recovered_o(clk_out_from_recovered_o),
    .clk_out_enable_o(clk_out_enable_o), .alt_pinout_o(alt_pinout_o),
    .soft_reset_o(soft_reset_o), .test_pattern_onehot_o(test_pattern_onehot_o));

`default_nettype wire

// *** verilog/mgmt_serial_slave.v ***
// Serial management interface slave: frame decode, address match and read data shifting.
`timescale 1ns/100ps
`default_nettype none
`include "phy_aux_control_map.vh"

module mgmt_serial_slave (
    input  wire        core_clk_i,
    input  wire        rst_i,
    input  wire        mdc_rise_i,
    input  wire        mdio_in_i,
    input  wire [4:0]  phy_addr_i,
    input  wire        broadcast_en_i,
    input  wire [15:0] rd_data_i,
    output reg  [4:0]  reg_addr_o,
    output reg         wr_stb_o,
    output reg  [15:0] wr_data_o,
    output reg         mdio_o,
    output reg         mdio_oe_o
);

    localparam [3:0] S_PRE  = 4'h1;
    localparam [3:0] S_HDR  = 4'h2;
    localparam [3:0] S_TA   = 4'h4;
    localparam [3:0] S_DATA = 4'h8;

    reg [3:0]  state_reg;
    reg [5:0]  count_reg;
    reg [12:0] hdr_reg;
    reg [15:0] shift_reg;
    reg        is_read_reg;
    reg        accept_reg;

    wire [12:0] hdr_next = {hdr_reg[11:0], mdio_in_i};
    wire [1:0]  hdr_op   = hdr_next[11:10];
    wire [4:0]  hdr_phy  = hdr_next[9:5];
    wire        hdr_st   = hdr_next[12];
    wire        addr_hit = (hdr_phy == phy_addr_i);
    // While broadcast is enabled, a write to the broadcast address is taken whatever the local address is.
    wire        bc_hit   = broadcast_en_i && (hdr_phy == `BROADCAST_PHY_ADDR)
                           && (hdr_op == `MDIO_OP_WRITE); // RL6

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg   <= S_PRE;
            count_reg   <= 6'h00;
            hdr_reg     <= 13'h0000;
            shift_reg   <= 16'h0000;
            is_read_reg <= 1'b0;
            accept_reg  <= 1'b0;
            reg_addr_o  <= 5'h00;
            wr_stb_o    <= 1'b0;
            wr_data_o   <= 16'h0000;
            mdio_o      <= 1'b0;
            mdio_oe_o   <= 1'b0;
        end else begin
            wr_stb_o <= 1'b0;
            if (mdc_rise_i) begin
                case (state_reg)
                    S_PRE: begin
                        mdio_oe_o <= 1'b0;
                        if (mdio_in_i) begin
                            if (count_reg != 6'd`PREAMBLE_BITS) begin
                                count_reg <= count_reg + 6'h01;
                            end
                        end else if (count_reg == 6'd`PREAMBLE_BITS) begin
                            state_reg <= S_HDR;
                            count_reg <= 6'h00;
                        end else begin
                            count_reg <= 6'h00;
                        end
                    end
                    S_HDR: begin
                        hdr_reg   <= hdr_next;
                        count_reg <= count_reg + 6'h01;
                        if (count_reg == 6'd`HEADER_BITS - 6'h01) begin
                            count_reg   <= 6'h00;
                            reg_addr_o  <= hdr_next[4:0];
                            is_read_reg <= (hdr_op == `MDIO_OP_READ);
                            accept_reg  <= hdr_st && (hdr_op != 2'h0) && (hdr_op != 2'h3)
                                           && (addr_hit || bc_hit);
                            state_reg   <= S_TA;
                        end
                    end
                    S_TA: begin
                        count_reg <= count_reg + 6'h01;
                        if (count_reg == 6'h00) begin
                            if (accept_reg && is_read_reg) begin
                                mdio_o    <= 1'b0;
                                mdio_oe_o <= 1'b1;
                                shift_reg <= rd_data_i;
                            end
                        end else begin
                            count_reg <= 6'h00;
                            state_reg <= S_DATA;
                            if (accept_reg && is_read_reg) begin
                                mdio_o    <= shift_reg[15];
                                shift_reg <= {shift_reg[14:0], 1'b0};
                            end
                        end
                    end
                    S_DATA: begin
                        count_reg <= count_reg + 6'h01;
                        if (accept_reg && is_read_reg) begin
                            mdio_o    <= shift_reg[15];
                            shift_reg <= {shift_reg[14:0], 1'b0};
                        end else begin
                            shift_reg <= {shift_reg[14:0], mdio_in_i};
                        end
                        if (count_reg == 6'd`DATA_BITS - 6'h01) begin
                            count_reg <= 6'h00;
                            state_reg <= S_PRE;
                            mdio_oe_o <= 1'b0;
                            if (accept_reg && !is_read_reg) begin
                                wr_stb_o  <= 1'b1;
                                wr_data_o <= {shift_reg[14:0], mdio_in_i};
                            end
                        end
                    end
                    default: begin
                        state_reg <= S_PRE;
                        count_reg <= 6'h00;
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// *** verilog/phy_aux_control_map.vh ***
// Register offsets, field positions, reset values and timing counts of the auxiliary control bank.
`ifndef PHY_AUX_CONTROL_MAP_VH
`define PHY_AUX_CONTROL_MAP_VH

`define ADDR_COMMON_DRIVER_TEST_CONTROL 5'h1b
`define ADDR_GENERAL_CONTROL_TWO        5'h1c
`define BROADCAST_PHY_ADDR              5'h1f

`define BIT_TEN_MB_PATTERN_ENABLE       4
`define BIT_TEST_PATTERN_SELECT_HI      1
`define BIT_TEST_PATTERN_SELECT_LO      0

`define BIT_SYNC_TRANSMIT_ENABLE        13
`define BIT_RECOVERED_CLOCK_ON_OUTPUT   12
`define BIT_BROADCAST_WRITE_ENABLE      11
`define BIT_ALT_PINOUT_ENABLE           10
`define BIT_SOFT_RESET                  9
`define BIT_CLOCK_OUTPUT_DISABLE        1
`define BIT_GCR2_SPARE                  0

`define RST_TEN_MB_PATTERN_ENABLE       1'h0
`define RST_TEST_PATTERN_SELECT         2'h0
`define RST_GCR2_CONTROL                1'h0

`define PATTERN_EOP_A                   2'h0
`define PATTERN_EOP_B                   2'h1
`define PATTERN_LINK_PULSES             2'h2
`define PATTERN_TONE                    2'h3

`define CORE_CLK_MHZ                    20
`define SOFT_RESET_NS                   400
`define SOFT_RESET_CYCLES               8'h08
`define PREAMBLE_BITS                   32
`define HEADER_BITS                     13
`define DATA_BITS                       16

`define MDIO_OP_WRITE                   2'h1
`define MDIO_OP_READ                    2'h2

`endif

// *** verilog/phy_aux_control_regs.v ***
// Auxiliary control register bank: test pattern selector and general control register two.
//
// Overview of operation
// RL1 - Selector picks EOP A, EOP B, pulses, tone.
// RL2 - Sync bit, 100 Mb, MII/master: recovered transmit clock.
// RL3 - Otherwise transmitter follows the local reference clock.
// RL4 - Recovered-clock bit at 100 Mb drives output pin.
// RL5 - Bit clear or 10 Mb: output carries reference.
// RL6 - Broadcast bit accepts writes to address 0x1F.
// RL7 - Alternate pinout reorders pins, enables clock output.
// RL8 - Soft reset spares registers, then clears itself.
// RL9 - Reserved bits 15:14, 8:2 read zero always.
// RL10 - Disable bit stops clock output; strap sets reset.
// RL11 - Selector acts only while pattern enable bit set.
// RL12 - Host writes zero to bit 0; soft reset transient.
`timescale 1ns/100ps
`default_nettype none
`include "phy_aux_control_map.vh"

module phy_aux_control_regs (
    input  wire       core_clk_i,
    input  wire       rst_i,
    input  wire       mdc_i,
    input  wire       mdio_i,
    input  wire [4:0] phy_addr_i,
    input  wire       link_100_i,
    input  wire       mac_sync_capable_i,
    input  wire       clk_out_disable_strap_i,
    output wire       mdio_o,
    output wire       mdio_oe_o,
    output reg        tx_clk_from_recovered_o,
    output reg        clk_out_from_recovered_o,
    output reg        clk_out_enable_o,
    output reg        alt_pinout_o,
    output reg        soft_reset_o,
    output reg  [3:0] test_pattern_onehot_o
);

    //------------------------------------------------------------------
    // Input synchronisers
    //------------------------------------------------------------------
    reg [1:0] mdc_sync_reg;
    reg [1:0] mdio_sync_reg;
    reg [1:0] link_sync_reg;
    reg [1:0] mac_sync_reg;
    reg [1:0] strap_sync_reg;
    reg [4:0] phy_addr_sync0_reg;
    reg [4:0] phy_addr_sync1_reg;
    reg       mdc_last_reg;

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mdc_sync_reg   <= 2'h0;
            mdio_sync_reg  <= 2'h0;
            link_sync_reg  <= 2'h0;
            mac_sync_reg   <= 2'h0;
            strap_sync_reg <= 2'h0;
            phy_addr_sync0_reg <= 5'h00;
            phy_addr_sync1_reg <= 5'h00;
            mdc_last_reg   <= 1'b0;
        end else begin
            mdc_sync_reg   <= {mdc_sync_reg[0], mdc_i};
            mdio_sync_reg  <= {mdio_sync_reg[0], mdio_i};
            link_sync_reg  <= {link_sync_reg[0], link_100_i};
            mac_sync_reg   <= {mac_sync_reg[0], mac_sync_capable_i};
            strap_sync_reg <= {strap_sync_reg[0], clk_out_disable_strap_i};
            phy_addr_sync0_reg <= phy_addr_i;
            phy_addr_sync1_reg <= phy_addr_sync0_reg;
            mdc_last_reg   <= mdc_sync_reg[1];
        end
    end

    wire mdc_rise = mdc_sync_reg[1] && !mdc_last_reg;

    //------------------------------------------------------------------
    // Management access
    //------------------------------------------------------------------
    reg        pattern_enable_reg;
    reg [1:0]  pattern_select_reg;
    reg        sync_tx_reg;
    reg        recovered_out_reg;
    reg        broadcast_reg;
    reg        alt_pinout_reg;
    reg        clk_out_disable_reg;
    reg        spare_bit_reg;
    reg        strap_loaded_reg;
    reg [1:0]  strap_wait_reg;
    reg [7:0]  soft_count_reg;
    reg [15:0] rd_data;

    wire [4:0]  reg_addr;
    wire        wr_stb;
    wire [15:0] wr_data;

    mgmt_serial_slave u_slave (
        .core_clk_i     (core_clk_i),
        .rst_i          (rst_i),
        .mdc_rise_i     (mdc_rise),
        .mdio_in_i      (mdio_sync_reg[1]),
        .phy_addr_i     (phy_addr_sync1_reg),
        .broadcast_en_i (broadcast_reg),
        .rd_data_i      (rd_data),
        .reg_addr_o     (reg_addr),
        .wr_stb_o       (wr_stb),
        .wr_data_o      (wr_data),
        .mdio_o         (mdio_o),
        .mdio_oe_o      (mdio_oe_o)
    );

    function is_addr;
        input [4:0] addr;
        input [4:0] target;
        begin
            is_addr = (addr == target);
        end
    endfunction

    wire soft_active = (soft_count_reg != 8'h00);

    //------------------------------------------------------------------
    // Read data
    //------------------------------------------------------------------
    always @* begin
        rd_data = 16'h0000;
        if (is_addr(reg_addr, `ADDR_COMMON_DRIVER_TEST_CONTROL)) begin
            rd_data[`BIT_TEN_MB_PATTERN_ENABLE] = pattern_enable_reg;
            rd_data[`BIT_TEST_PATTERN_SELECT_HI:`BIT_TEST_PATTERN_SELECT_LO] =
                pattern_select_reg;
        end else if (is_addr(reg_addr, `ADDR_GENERAL_CONTROL_TWO)) begin
            // Bits 15:14 and 8:2 stay zero.
            rd_data[`BIT_SYNC_TRANSMIT_ENABLE]      = sync_tx_reg; // RL9
            rd_data[`BIT_RECOVERED_CLOCK_ON_OUTPUT] = recovered_out_reg;
            rd_data[`BIT_BROADCAST_WRITE_ENABLE]    = broadcast_reg;
            rd_data[`BIT_ALT_PINOUT_ENABLE]         = alt_pinout_reg;
            rd_data[`BIT_SOFT_RESET]                = soft_active;
            rd_data[`BIT_CLOCK_OUTPUT_DISABLE]      = clk_out_disable_reg;
            rd_data[`BIT_GCR2_SPARE]                = spare_bit_reg; // RL12
        end
    end

    //------------------------------------------------------------------
    // Register writes, strap capture and soft reset timing
    //------------------------------------------------------------------
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pattern_enable_reg  <= `RST_TEN_MB_PATTERN_ENABLE;
            pattern_select_reg  <= `RST_TEST_PATTERN_SELECT;
            sync_tx_reg         <= `RST_GCR2_CONTROL;
            recovered_out_reg   <= `RST_GCR2_CONTROL;
            broadcast_reg       <= `RST_GCR2_CONTROL;
            alt_pinout_reg      <= `RST_GCR2_CONTROL;
            clk_out_disable_reg <= `RST_GCR2_CONTROL;
            spare_bit_reg       <= `RST_GCR2_CONTROL;
            strap_loaded_reg    <= 1'b0;
            strap_wait_reg      <= 2'h0;
            soft_count_reg      <= 8'h00;
        end else begin
            // The strap is sampled once it has crossed the synchroniser.
            if (!strap_loaded_reg) begin
                strap_wait_reg <= strap_wait_reg + 2'h1;
                if (strap_wait_reg == 2'h2) begin
                    clk_out_disable_reg <= strap_sync_reg[1]; // RL10
                    strap_loaded_reg    <= 1'b1;
                end
            end
            if (soft_active) begin
                soft_count_reg <= soft_count_reg - 8'h01; // RL8
            end
            if (wr_stb && is_addr(reg_addr, `ADDR_COMMON_DRIVER_TEST_CONTROL)) begin
                pattern_enable_reg <= wr_data[`BIT_TEN_MB_PATTERN_ENABLE];
                pattern_select_reg <=
                    wr_data[`BIT_TEST_PATTERN_SELECT_HI:`BIT_TEST_PATTERN_SELECT_LO];
            end
            if (wr_stb && is_addr(reg_addr, `ADDR_GENERAL_CONTROL_TWO)) begin
                sync_tx_reg         <= wr_data[`BIT_SYNC_TRANSMIT_ENABLE];
                recovered_out_reg   <= wr_data[`BIT_RECOVERED_CLOCK_ON_OUTPUT];
                broadcast_reg       <= wr_data[`BIT_BROADCAST_WRITE_ENABLE];
                alt_pinout_reg      <= wr_data[`BIT_ALT_PINOUT_ENABLE];
                clk_out_disable_reg <= wr_data[`BIT_CLOCK_OUTPUT_DISABLE];
                spare_bit_reg       <= wr_data[`BIT_GCR2_SPARE];
                strap_loaded_reg    <= 1'b1;
                if (wr_data[`BIT_SOFT_RESET]) begin
                    soft_count_reg <= `SOFT_RESET_CYCLES; // RL8
                end
            end
        end
    end

    //------------------------------------------------------------------
    // Control outputs
    //------------------------------------------------------------------
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_clk_from_recovered_o  <= 1'b0;
            clk_out_from_recovered_o <= 1'b0;
            clk_out_enable_o         <= 1'b0;
            alt_pinout_o             <= 1'b0;
            soft_reset_o             <= 1'b0;
            test_pattern_onehot_o    <= 4'h0;
        end else begin
            tx_clk_from_recovered_o  <= sync_tx_reg && link_sync_reg[1]
                                        && mac_sync_reg[1]; // RL2 RL3
            clk_out_from_recovered_o <= recovered_out_reg && link_sync_reg[1]; // RL4 RL5
            clk_out_enable_o         <= strap_loaded_reg
                                        && (!clk_out_disable_reg || alt_pinout_reg); // RL10 RL7
            alt_pinout_o             <= alt_pinout_reg; // RL7
            soft_reset_o             <= soft_active; // RL8
            test_pattern_onehot_o    <= 4'h0;
            if (pattern_enable_reg) begin // RL11
                case (pattern_select_reg) // RL1
                    `PATTERN_EOP_A:       test_pattern_onehot_o <= 4'h1;
                    `PATTERN_EOP_B:       test_pattern_onehot_o <= 4'h2;
                    `PATTERN_LINK_PULSES: test_pattern_onehot_o <= 4'h4;
                    `PATTERN_TONE:        test_pattern_onehot_o <= 4'h8;
                    default:              test_pattern_onehot_o <= 4'h0;
                endcase
            end
        end
    end

endmodule
`default_nettype wire
